// ==== tsp_serial_port.v ====
// Purpose: Serial slave port, register file, alert pins and conversion
//          sequencer of a digital temperature sensor.
// Assumes: sclk idles high between transfers; the converter answers each
//          conv_start with one adc_done pulse on ref_clk.
// Notes: Pins are oversampled, so sclk must stay well below ref_clk / 4.
// Summary of operation
// - Read data changes on the falling serial clock edge.
// - Input data is captured on the rising serial clock edge.
// - Serial traffic is honoured only while chip select is low.
// - The data output is released once chip select goes high.
// - The data output is driven after chip select falls.
// - Limit alert starts as active-low interrupt, open-drain, pulling low.
// - Critical alert starts active low, open-drain, pulling low only.
// - Results start in 13-bit format, 0.0625 degrees per step.
// - Four modes: normal, one-shot, one sample per second, shutdown.
// - Config bits 6 to 5 select the mode: 00, 01, 10, 11.
// - Config bit 7 set selects 16-bit results and limits.
// - In interrupt mode any register read clears both alert outputs.
`timescale 1ns/1ps
`default_nettype none
`include "tsp_defines.vh"
module tsp_serial_port #(
    parameter [7:0]  DEVICE_ID  = 8'hc5,
    parameter [31:0] SPS_CYCLES = `TSP_ONE_SEC_NS / `TSP_CLK_NS
) (
    input  wire        ref_clk,
    input  wire        nrst,
    input  wire        sclk,
    input  wire        cs_n,
    input  wire        din,
    output reg         dout,
    output reg         dout_oe,
    output reg         limit_alert_o,
    output reg         limit_alert_oe,
    output reg         critical_alert_o,
    output reg         critical_alert_oe,
    input  wire [15:0] adc_code,
    input  wire        adc_done,
    output reg         conv_start,
    output reg         conv_busy,
    output reg  [1:0]  conv_mode
);
    // DEVICE_ID default is arbitrary.
    localparam CV_IDLE = 2'h0;
    localparam CV_BUSY = 2'h1;
    localparam CV_WAIT = 2'h2;

    wire [2:0] pins_s;
    // Reset values match the idle pins, so no false select or edge follows.
    tsp_sync #(.W(3), .INIT(3'h6)) u_sync (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .d       ({cs_n, sclk, din}),
        .q       (pins_s)
    );
    wire cs_s   = pins_s[2];
    wire sclk_s = pins_s[1];
    wire din_s  = pins_s[0];

    reg        sclk_d;
    reg  [5:0] bit_cnt;
    reg  [7:0] cmd;
    reg  [15:0] rx;
    reg  [15:0] tx;
    reg  [7:0] cfg;
    reg  [15:0] temp;
    reg  [15:0] tcrit;
    reg  [15:0] thigh;
    reg  [15:0] tlow;
    reg  [2:0] flags;
    reg        int_act;
    reg        crit_act;
    reg  [1:0] cv_state;
    reg  [31:0] pace;
    reg        oneshot_req;

    wire sclk_rise = sclk_s & ~sclk_d;
    wire sclk_fall = ~sclk_s & sclk_d;
    wire active    = ~cs_s;
    wire rx_rise   = active & sclk_rise;
    wire [7:0]  shift_byte = {rx[6:0], din_s};
    wire [15:0] shift_word = {rx[14:0], din_s};
    wire [5:0]  next_bits  = bit_cnt + 6'h01;
    wire        cmd_done   = rx_rise && (next_bits == `TSP_CMD_BITS);
    wire        cmd_rd     = shift_byte[`TSP_CMD_RD_BIT];
    wire [2:0]  cmd_addr   = shift_byte[`TSP_CMD_ADDR_HI:`TSP_CMD_ADDR_LO];
    wire [2:0]  wr_addr    = cmd[`TSP_CMD_ADDR_HI:`TSP_CMD_ADDR_LO];
    wire        wr_word    = (wr_addr == `TSP_ADDR_TCRIT) ||
                             (wr_addr == `TSP_ADDR_THIGH) ||
                             (wr_addr == `TSP_ADDR_TLOW);
    wire        wr_phase   = rx_rise && !cmd[`TSP_CMD_RD_BIT];
    wire        wr_byte    = wr_phase && (next_bits == `TSP_BYTE1_BITS) &&
                             !wr_word;
    wire        wr_full    = wr_phase && (next_bits == `TSP_BYTE2_BITS) &&
                             wr_word;
    wire        any_read   = cmd_done && cmd_rd;
    wire        cfg_write  = wr_byte && (wr_addr == `TSP_ADDR_CONFIG);
    wire [1:0]  mode       = cfg[`TSP_CFG_MODE_HI:`TSP_CFG_MODE_LO];
    wire        res16      = cfg[`TSP_CFG_RES_BIT];
    wire        cmp_mode   = cfg[`TSP_CFG_CMP_BIT];

    // In 13-bit mode the three low bits are flags, so the compare drops them.
    wire [15:0] cmp_mask = res16 ? 16'hffff : `TSP_LOW3_MASK;
    wire signed [15:0] t_m = $signed(adc_code & cmp_mask);
    wire over_crit = t_m >= $signed(tcrit & cmp_mask);
    wire over_high = t_m >  $signed(thigh & cmp_mask);
    wire under_low = t_m <  $signed(tlow & cmp_mask);

    reg [15:0] rd_data;
    always @* begin
        case (cmd_addr)
            `TSP_ADDR_STATUS: rd_data = {conv_busy, 4'h0, flags, 8'h00};
            `TSP_ADDR_CONFIG: rd_data = {cfg, 8'h00};
            `TSP_ADDR_TEMP:   rd_data = temp;
            `TSP_ADDR_ID:     rd_data = {DEVICE_ID, 8'h00};
            `TSP_ADDR_TCRIT:  rd_data = tcrit;
            `TSP_ADDR_THIGH:  rd_data = thigh;
            `TSP_ADDR_TLOW:   rd_data = tlow;
            default:          rd_data = 16'h0000;
        endcase
    end

    // Serial shifter: bytes MSB first, command byte first.
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sclk_d  <= 1'b1;
            bit_cnt <= 6'h00;
            cmd     <= 8'h00;
            rx      <= 16'h0000;
            tx      <= 16'h0000;
            dout    <= 1'b0;
            dout_oe <= 1'b0;
        end else begin
            sclk_d  <= sclk_s;
            dout_oe <= active;
            if (!active) begin
                bit_cnt <= 6'h00;
                cmd     <= 8'h00;
                dout    <= 1'b0;
            end else begin
                if (rx_rise) begin
                    rx <= shift_word;
                    if (bit_cnt != `TSP_BITS_MAX)
                        bit_cnt <= next_bits;
                    if (cmd_done) begin
                        cmd <= shift_byte;
                        tx  <= cmd_rd ? rd_data : 16'h0000;
                    end
                end
                if (sclk_fall && cmd[`TSP_CMD_RD_BIT]) begin
                    dout <= tx[15];
                    tx   <= {tx[14:0], 1'b0};
                end
            end
        end
    end

    // Register writes and the result register.
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cfg   <= `TSP_CFG_RESET;
            tcrit <= `TSP_TCRIT_RESET;
            thigh <= `TSP_THIGH_RESET;
            tlow  <= `TSP_TLOW_RESET;
            temp  <= 16'h0000;
            flags <= 3'h0;
        end else begin
            if (cfg_write)
                cfg <= shift_byte;
            if (wr_full && wr_addr == `TSP_ADDR_TCRIT)
                tcrit <= shift_word;
            if (wr_full && wr_addr == `TSP_ADDR_THIGH)
                thigh <= shift_word;
            if (wr_full && wr_addr == `TSP_ADDR_TLOW)
                tlow <= shift_word;
            if (adc_done) begin
                flags <= {over_crit, over_high, under_low};
                if (res16)
                    temp <= adc_code;
                else
                    temp <= {adc_code[15:3], over_crit, over_high,
                             under_low};
            end
        end
    end

    // Alerts. A new event in the same cycle as a clearing read wins.
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            int_act           <= 1'b0;
            crit_act          <= 1'b0;
            limit_alert_o     <= 1'b0;
            limit_alert_oe    <= 1'b0;
            critical_alert_o  <= 1'b0;
            critical_alert_oe <= 1'b0;
        end else begin
            if (adc_done && (over_high || under_low))
                int_act <= 1'b1;
            else if (cmp_mode && adc_done)
                int_act <= 1'b0;
            else if ((!cmp_mode && any_read) || cfg_write)
                int_act <= 1'b0;
            if (adc_done && over_crit)
                crit_act <= 1'b1;
            else if (cmp_mode && adc_done)
                crit_act <= 1'b0;
            else if ((!cmp_mode && any_read) || cfg_write)
                crit_act <= 1'b0;
            // Open drain: only ever pull low, never drive high.
            limit_alert_o     <= 1'b0;
            critical_alert_o  <= 1'b0;
            limit_alert_oe    <= int_act ^ cfg[`TSP_CFG_INTPOL];
            critical_alert_oe <= crit_act ^ cfg[`TSP_CFG_CRIT_POL];
        end
    end

    // Conversion sequencer, driven by the mode field, one-shot config writes and adc_done.
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cv_state    <= CV_IDLE;
            pace        <= 32'h0000_0000;
            conv_start  <= 1'b0;
            conv_busy   <= 1'b0;
            conv_mode   <= `TSP_MODE_NORMAL;
            oneshot_req <= 1'b0;
        end else begin
            conv_mode  <= mode;
            conv_start <= 1'b0;
            if (cfg_write &&
                shift_byte[`TSP_CFG_MODE_HI:`TSP_CFG_MODE_LO] ==
                `TSP_MODE_ONESHOT)
                oneshot_req <= 1'b1;
            if (pace != 32'h0000_0000)
                pace <= pace - 32'h0000_0001;
            case (cv_state)
                CV_IDLE: begin
                    if (mode == `TSP_MODE_NORMAL ||
                        mode == `TSP_MODE_ONESPS ||
                        (mode == `TSP_MODE_ONESHOT && oneshot_req)) begin
                        conv_start  <= 1'b1;
                        conv_busy   <= 1'b1;
                        oneshot_req <= 1'b0;
                        pace        <= SPS_CYCLES;
                        cv_state    <= CV_BUSY;
                    end
                end
                CV_BUSY: begin
                    if (adc_done) begin
                        conv_busy <= 1'b0;
                        cv_state  <= (mode == `TSP_MODE_ONESPS) ?
                                     CV_WAIT : CV_IDLE;
                    end
                end
                CV_WAIT: begin
                    if (mode != `TSP_MODE_ONESPS ||
                        pace == 32'h0000_0000)
                        cv_state <= CV_IDLE;
                end
                default: cv_state <= CV_IDLE;
            endcase
        end
    end
endmodule // tsp_serial_port
`default_nettype wire

// ==== tsp_defines.vh ====
// Purpose: Constants for the temperature sensor serial port.
// Assumes: Included by its bare name from the design files.
// Notes: Offsets are register addresses carried in the command byte.
`ifndef TSP_DEFINES_VH
`define TSP_DEFINES_VH

`define TSP_ADDR_STATUS   3'h0
`define TSP_ADDR_CONFIG   3'h1
`define TSP_ADDR_TEMP     3'h2
`define TSP_ADDR_ID       3'h3
`define TSP_ADDR_TCRIT    3'h4
`define TSP_ADDR_THIGH    3'h6
`define TSP_ADDR_TLOW     3'h7

`define TSP_CMD_RD_BIT    6
`define TSP_CMD_ADDR_HI   5
`define TSP_CMD_ADDR_LO   3

`define TSP_CFG_RES_BIT   7
`define TSP_CFG_MODE_HI   6
`define TSP_CFG_MODE_LO   5
`define TSP_CFG_CMP_BIT   4
`define TSP_CFG_INTPOL    3
`define TSP_CFG_CRIT_POL  2

`define TSP_MODE_NORMAL   2'h0
`define TSP_MODE_ONESHOT  2'h1
`define TSP_MODE_ONESPS   2'h2
`define TSP_MODE_SHUTDOWN 2'h3

`define TSP_CFG_RESET     8'h00
`define TSP_TCRIT_RESET   16'h4980
`define TSP_THIGH_RESET   16'h2000
`define TSP_TLOW_RESET    16'h0500
`define TSP_LOW3_MASK     16'hfff8

`define TSP_CMD_BITS      6'h08
`define TSP_BYTE1_BITS    6'h10
`define TSP_BYTE2_BITS    6'h18
`define TSP_BITS_MAX      6'h3f

`define TSP_ONE_SEC_NS    1000000000
`define TSP_CLK_NS        20

`endif

// ==== tsp_sync.v ====
// Purpose: Two-stage synchroniser, one stage pair per bit.
// Assumes: Inputs are asynchronous to ref_clk.
// Notes: Only the second stage is visible outside.
`timescale 1ns/1ps
`default_nettype none
module tsp_sync #(
    parameter W = 3,
    parameter [2:0] INIT = 3'h0
) (
    input  wire         ref_clk,
    input  wire         nrst,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] meta;
    reg [W-1:0] stab;
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    meta[i] <= INIT[i];
                    stab[i] <= INIT[i];
                end else begin
                    meta[i] <= d[i];
                    stab[i] <= meta[i];
                end
            end
        end
    endgenerate
    assign q = stab;
endmodule // tsp_sync
`default_nettype wire

// ==== tsp_port_monitor.sv ====
// Purpose: Port assertions for the sensor serial port.
// Assumes: Bound to every tsp_serial_port instance.
// Notes: Pin timing allows for the two-flop input synchroniser.
`timescale 1ns/1ps
`default_nettype none
module tsp_port_monitor (
    input wire logic       ref_clk,
    input wire logic       nrst,
    input wire logic       sclk,
    input wire logic       cs_n,
    input wire logic       dout,
    input wire logic       dout_oe,
    input wire logic       limit_alert_o,
    input wire logic       limit_alert_oe,
    input wire logic       critical_alert_o,
    input wire logic       adc_done,
    input wire logic       conv_start,
    input wire logic       conv_busy,
    input wire logic [1:0] conv_mode
);
    logic [6:0] sclk_h;
    wire logic  fell_near;
    // A pin fall seen one to five samples ago; sync delay sits inside.
    assign fell_near = |(~sclk_h[5:1] & sclk_h[6:2]);
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) sclk_h <= 7'h7f;
        else sclk_h <= {sclk_h[5:0], sclk};
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    oe_drive_a: assert property (
        $fell(cs_n) ##1 !cs_n [*5] |-> dout_oe) else $error("oe late");
    oe_release_a: assert property (
        $rose(cs_n) ##1 cs_n [*5] |-> !dout_oe) else $error("oe held");
    idle_quiet_a: assert property (
        cs_n [*6] |=> $stable(dout) && !dout_oe) else $error("idle busy");
    dout_edge_a: assert property (
        !cs_n && $changed(dout) |-> fell_near) else $error("dout edge");
    limit_od_a: assert property (
        !limit_alert_o) else $error("limit drives high");
    crit_od_a: assert property (
        !critical_alert_o) else $error("crit drives high");
    alert_cause_a: assert property (
        $rose(limit_alert_oe) |-> $past(adc_done, 2) ||
        $past(adc_done, 3) || $past(adc_done, 4)) else $error("alert");
    restart_a: assert property (
        adc_done && conv_mode == 2'h0 ##1 conv_mode == 2'h0
        |-> ##[0:2] conv_start) else $error("no restart");
    shut_a: assert property (
        (conv_mode == 2'h3) [*3] |-> !conv_start) else $error("shutdown");
    pulse_a: assert property (
        conv_start |=> !conv_start && conv_busy) else $error("start");
endmodule // tsp_port_monitor
bind tsp_serial_port tsp_port_monitor mon (.ref_clk(ref_clk),
    .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .dout(dout),
    .dout_oe(dout_oe), .limit_alert_o(limit_alert_o),
    .limit_alert_oe(limit_alert_oe), .critical_alert_o(critical_alert_o),
    .adc_done(adc_done), .conv_start(conv_start),
    .conv_busy(conv_busy), .conv_mode(conv_mode));
`default_nettype wire

// ==== tsp_host_model.sv ====
// Purpose: Serial master that frames transfers to the sensor port.
// Assumes: Clock idles high, 160 ns period, only inside frames.
// Notes: Sampling late in the high phase tolerates the port's delay.
`timescale 1ns/1ps
`default_nettype none
module tsp_host_model (
    output var logic sclk,
    output var logic cs_n,
    output var logic din,
    input  wire logic dout,
    input  wire logic dout_oe
);
    wire logic miso;
    // The data pin has no keeper, so a released line reads inverted.
    assign miso = dout_oe ? dout : ~dout;
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
    end
    task automatic frame(input logic sel, input logic [23:0] tx,
                         input int nbits, output logic [23:0] rx);
        rx = 24'h00_0000;
        #7 cs_n = !sel;
        #40;
        for (int i = 0; i < nbits; i++) begin
            sclk = 1'b0;
            din = tx[23 - i];
            #80 sclk = 1'b1;
            #75 rx = {rx[22:0], miso};
            #5;
        end
        din = ~din;
        #40 cs_n = 1'b1;
        // A frame spans whole clock periods, so every pin edge keeps one offset.
        #193;
    endtask
endmodule // tsp_host_model
`default_nettype wire

// ==== tsp_serial_port_tb_top.sv ====
// Purpose: Self-checking bench for the sensor serial port.
// Assumes: Converter answers each start after four cycles.
// Notes: Short one-sample-per-second period keeps the run brief.
`timescale 1ns/1ps
`default_nettype none
module tsp_serial_port_tb_top;
    logic        ref_clk, nrst, adc_done;
    logic [15:0] adc_code, d;
    logic [23:0] rx;
    wire logic   sclk, cs_n, din, dout, dout_oe, conv_start, conv_busy;
    wire logic   la_o, la_oe, ca_o, ca_oe;
    wire logic [1:0] conv_mode;
    int          miscompares, n_checks, cycles, starts, pend;
    // DEVICE_ID value is arbitrary.
    tsp_serial_port #(.DEVICE_ID(8'h5a), .SPS_CYCLES(32'h0000_00c8)) dut (
        .ref_clk(ref_clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n),
        .din(din), .dout(dout), .dout_oe(dout_oe), .limit_alert_o(la_o),
        .limit_alert_oe(la_oe), .critical_alert_o(ca_o),
        .critical_alert_oe(ca_oe), .adc_code(adc_code),
        .adc_done(adc_done), .conv_start(conv_start),
        .conv_busy(conv_busy), .conv_mode(conv_mode));
    tsp_host_model host (.sclk(sclk), .cs_n(cs_n), .din(din),
        .dout(dout), .dout_oe(dout_oe));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        starts <= starts + conv_start;
        adc_done <= #1 (pend == 1);
        pend <= conv_start ? 4 : (pend > 0 ? pend - 1 : 0);
        if (cycles == 20000) begin
            miscompares++;
            summarize();
        end
    end
    task automatic summarize();
        if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [2:0] a, input int nb);
        host.frame(1'b1, {2'b01, a, 19'h0_0000}, 8 + nb, rx);
        d = (nb == 8) ? {8'h00, rx[7:0]} : rx[15:0];
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        host.frame(1'b1, {2'b00, a, 3'h0, v, 8'h00}, 16, rx);
        repeat (6) @(posedge ref_clk);
    endtask
    task automatic t_reset();
        check({11'h000, la_oe, ca_oe, la_o, ca_o, dout_oe}, 16'h0000);
        rd(3'h1, 8);
        check(d, 16'h0000);
        rd(3'h3, 8);
        check(d, 16'h005a);
    endtask
    task automatic t_temp13();
        rd(3'h2, 16);
        check(d, 16'h1238);
        host.frame(1'b0, 24'h08_6000, 16, rx);
        rd(3'h1, 8);
        check(d, 16'h0000);
    endtask
    task automatic t_modes();
        logic [1:0] m;
        int s0;
        int lo[4] = '{20, 0, 1, 0};
        int hi[4] = '{300, 0, 2, 0};
        for (int i = 1; i < 5; i++) begin
            m = i[1:0];
            wr(3'h1, {1'b0, m, 5'h00});
            check({14'h0000, conv_mode}, {14'h0000, m});
            repeat (20) @(posedge ref_clk);
            // The start counter is only sampled; clearing it would race.
            s0 = starts;
            repeat (300) @(posedge ref_clk);
            s0 = starts - s0;
            check({15'h0000, s0 >= lo[m] && s0 <= hi[m]}, 16'h0001);
        end
    endtask
    task automatic t_res16();
        adc_code <= #1 16'h1237;
        wr(3'h1, 8'h80);
        repeat (40) @(posedge ref_clk);
        rd(3'h2, 16);
        check(d, 16'h1237);
    endtask
    task automatic t_alert();
        adc_code <= #1 16'h4a00;
        wr(3'h1, 8'h20);
        repeat (30) @(posedge ref_clk);
        check({14'h0000, la_oe, ca_oe}, 16'h0003);
        rd(3'h1, 8);
        repeat (50) @(posedge ref_clk);
        check({14'h0000, la_oe, ca_oe}, 16'h0000);
    endtask
    initial begin
        nrst = 1'b0;
        adc_done = 1'b0;
        adc_code = 16'h123f;
        repeat (16) @(posedge ref_clk);
        nrst <= #1 1'b1;
        repeat (5) @(posedge ref_clk);
        t_reset();
        t_temp13();
        t_modes();
        t_res16();
        t_alert();
        summarize();
    end
endmodule // tsp_serial_port_tb_top
`default_nettype wire
